// [rip_cpu_model.sv]
/* CPU core stand-in: acknowledges any non-reset winner after LAT cycles.
   Assumes a registered winner. */
`timescale 1ns/1ps
module rip_cpu_model
    import rip_pkg::*;
#(parameter int LAT = 3)  // Cycles to finish the instruction in flight
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire rip_winner_t winner,
    output logic             irq_ack
);
    int cnt;  // Cycles the winner has waited
    // Slow service on purpose, so a level request must hold
    always_ff @(posedge clock)
        cnt <= (rst || !winner.valid || winner.is_reset || cnt == LAT) ? 0 : cnt + 1;
    assign irq_ack = (cnt == LAT);
endmodule // rip_cpu_model

// [rip_ctrl.sv]
/*
 * Reset-state initialisation and reset / interrupt priority resolution.
 * Assumes: one 20 MHz clock, synchronous active-high rst, inputs synchronous
 * to clock, an Avalon-MM master with waitrequest, and a CPU core that samples
 * the registered winner and fetches its vector at an instruction boundary.
 */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module rip_ctrl
    import rip_pkg::*;
#(
    parameter int NUM_SRC = NUM_MASKABLE  // Maskable source count
)
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // Avalon-MM register slave
    input  wire logic [15:0]             address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    input  wire logic [3:0]              byteenable,
    output logic      [31:0]             readdata,
    output logic      [1:0]              response,
    output logic                         waitrequest,
    // Mode pins and nonvolatile watchdog configuration
    input  wire logic                    mode_pin_a,
    input  wire logic                    mode_pin_b,
    input  wire logic                    watchdog_disable,
    // CPU core side
    input  wire logic                    cpu_i_mask,
    input  wire logic                    cpu_x_mask,
    input  wire logic                    irq_ack,
    output rip_winner_t                  winner,
    // Request lines
    input  wire rip_nmi_req_t            nmi_req,
    input  wire logic                    irq_pin_n,
    input  wire logic [NUM_SRC-1:0]      mask_req,
    input  wire logic [NUM_SRC-1:0]      mask_en,
    // Controls to peripherals
    output rip_sys_ctrl_t                sys_ctrl,
    output rip_ser_ctrl_t                ser_ctrl
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check: priority decode assumes exactly fifteen sources
    if (NUM_SRC != NUM_MASKABLE)
    begin : g_bad_count
        $error("rip_ctrl supports only fifteen maskable sources");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Priority field to default-order index
    function automatic logic [3:0] psel_to_index(input logic [3:0] psel);
        logic [3:0] idx;
        idx = 4'h0;
        unique case (psel)
            4'h0: idx = 4'ha;            // Timer overflow
            4'h1: idx = 4'hb;            // Accumulator overflow
            4'h2: idx = 4'hc;            // Accumulator edge
            4'h3: idx = 4'hd;            // Peripheral serial
            4'h4: idx = 4'he;            // Serial system
            4'h5: idx = 4'h0;            // Reserved acts as IRQ
            4'h6: idx = 4'h0;            // IRQ
            4'h7: idx = 4'h1;            // Real-time
            default: idx = psel - 4'h6;  // Captures and compares
        endcase
        return idx;
    endfunction

    // Default-order index to source identity
    function automatic rip_src_t index_to_src(input logic [3:0] idx);
        return rip_src_t'(5'(SRC_IRQ) + {1'b0, idx});
    endfunction

    // Source to fixed vector low byte, never touched by promotion
    function automatic logic [7:0] vector_low(input rip_src_t src);
        logic [7:0] v;
        v = 8'h00;
        unique case (src)
            SRC_POWER_ON:   v = 8'hfe;
            SRC_CLK_MON:    v = 8'hfc;
            SRC_WATCHDOG:   v = 8'hfa;
            SRC_ILLEGAL_OP: v = 8'hf8;
            SRC_SOFT_TRAP:  v = 8'hf6;
            SRC_NMI_PIN:    v = 8'hf4;
            SRC_IRQ:        v = 8'hf2;
            SRC_RTI:        v = 8'hf0;
            SRC_CAP4_CMP5:  v = 8'he0;
            SRC_TIMER_OVF:  v = 8'hde;
            SRC_ACC_OVF:    v = 8'hdc;
            SRC_ACC_EDGE:   v = 8'hda;
            SRC_PSERIAL:    v = 8'hd8;
            SRC_SERIAL:     v = 8'hd6;
            SRC_NONE:       v = 8'h00;
            // Captures 1-3 and compares 1-4 step down by two
            default:        v = 8'hee - 8'({3'(5'(src) - 5'(SRC_CAP1)), 1'b0});
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0] psel;            // Promoted source selector
    logic       boot_rom_read;   // Boot ROM visible
    logic       special_mode_bit;
    logic       mode_a_bit;
    logic       read_visibility_eclk_ctrl;
    logic [1:0] wd_rate;         // Watchdog rate
    logic       clk_mon_en;
    logic       start_delay;
    logic       irq_edge_mode;   // Zero: level sensitive
    logic       conv_pu;
    logic       nvm_prog;
    logic       wd_disabled;     // Captured watchdog disable
    logic [7:0] baud;
    logic [6:0] ser_bits;        // Serial control bits, see ser_ctrl
    logic       ack;             // Bus answer cycle
    logic       wr_go;           // Write takes effect now
    logic       rd_go;           // Read data being captured
    logic       irq_edge_seen;   // Latched IRQ falling edge
    logic       irq_pin_q;       // Previous IRQ pin level

    ////////////////////////////////////////////////////////////////////////////
    // Avalon handshake: every access gets exactly one wait cycle.
    // Costs one cycle but keeps read data from flip-flops.
    always_ff @(posedge clock)
    begin
        if (rst)
            ack <= 1'b0;
        else
            ack <= (read | write) & ~ack;
    end

    assign waitrequest = (read | write) & ~ack;
    assign wr_go       = write & ack;
    assign rd_go       = read & ~ack;

    // Byte lane 0 carries the priority and system control fields
    logic wr_low;
    assign wr_low = wr_go & byteenable[0];

    ////////////////////////////////////////////////////////////////////////////
    // Priority and mode register.
    // Synchronous reset samples the pins on every reset cycle, so the value
    // held is the one present at the last clock edge before reset is released.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            special_mode_bit          <= ~mode_pin_b;
            mode_a_bit                <= mode_pin_a;
            boot_rom_read             <= ~mode_pin_b & ~mode_pin_a;
            read_visibility_eclk_ctrl <= ~mode_pin_b & mode_pin_a;
        end
        else if (wr_low && address == ADDR_PRIO_MISC)
        begin
            read_visibility_eclk_ctrl <= writedata[BIT_VIS];
            // Mode bits change only while in a special mode
            if (special_mode_bit)
            begin
                special_mode_bit <= writedata[BIT_SPECIAL_MODE_BIT];
                mode_a_bit       <= writedata[BIT_MODE_A];
                boot_rom_read    <= writedata[BIT_BOOT_ROM] & writedata[BIT_SPECIAL_MODE_BIT];
            end
        end
        else if (!special_mode_bit)
            boot_rom_read <= 1'b0;
    end

    // Selector, guarded by the global mask against races
    always_ff @(posedge clock)
    begin
        if (rst)
            psel <= PSEL_RESET;
        else if (wr_low && address == ADDR_PRIO_MISC && cpu_i_mask)
            psel <= writedata[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // System controls
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wd_rate       <= WD_RATE_RESET;
            clk_mon_en    <= 1'b0;
            start_delay   <= 1'b1;
            irq_edge_mode <= 1'b0;
            conv_pu       <= 1'b0;
            nvm_prog      <= 1'b0;
            wd_disabled   <= watchdog_disable;
        end
        else if (wr_low && address == ADDR_SYS_CTRL)
        begin
            wd_rate       <= writedata[BIT_WD_RATE +: 2];
            clk_mon_en    <= writedata[BIT_CLK_MON];
            start_delay   <= writedata[BIT_START_DL];
            irq_edge_mode <= writedata[BIT_IRQ_EDGE];
            conv_pu       <= writedata[BIT_CONV_PU];
            nvm_prog      <= writedata[BIT_NVM_PROG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial and peripheral-serial controls, same reset in every mode
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            baud     <= BAUD_RESET;
            ser_bits <= 7'h00;
        end
        else if (wr_go && address == ADDR_SER_CTRL)
        begin
            if (byteenable[0])
                baud <= writedata[7:0];
            if (byteenable[1])
                ser_bits <= writedata[14:8];
        end
    end

    // Status flags stand at their reset values until the serial core runs
    logic tx_flags;
    always_ff @(posedge clock)
    begin
        if (rst)
            tx_flags <= 1'b1;
        else
            tx_flags <= tx_flags;
    end

    ////////////////////////////////////////////////////////////////////////////
    // External IRQ: level by default, optional falling-edge latch.
    // A new edge in the acknowledge cycle keeps the latch set.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irq_pin_q     <= 1'b1;
            irq_edge_seen <= 1'b0;
        end
        else
        begin
            irq_pin_q <= irq_pin_n;
            if (irq_pin_q && !irq_pin_n)
                irq_edge_seen <= 1'b1;
            else if (irq_ack)
                irq_edge_seen <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Maskable arbitration
    logic [NUM_SRC-1:0] pending;      // Enabled and unmasked
    logic [3:0]         promoted;     // Index of promoted source
    logic [3:0]         first_idx;    // Lowest pending index
    logic               any_pending;

    always_comb
    begin
        // IRQ has no local enable
        pending[0] = irq_edge_mode ? irq_edge_seen : ~irq_pin_n;
        pending[NUM_SRC-1:1] = mask_req[NUM_SRC-1:1] & mask_en[NUM_SRC-1:1];
        if (cpu_i_mask)
            pending = '0;
    end

    assign promoted    = psel_to_index(psel);
    assign any_pending = |pending;

    // Lowest index wins by default
    always_comb
    begin
        first_idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pending[i])
                first_idx = 4'(i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overall winner, non-maskable first
    rip_src_t next_source;

    always_comb
    begin
        if (nmi_req.power_on)
            next_source = SRC_POWER_ON;
        else if (nmi_req.clk_mon_fail && clk_mon_en)
            next_source = SRC_CLK_MON;
        else if (nmi_req.watchdog_timeout && !wd_disabled)
            next_source = SRC_WATCHDOG;
        else if (nmi_req.nmi_pin && !cpu_x_mask)
            next_source = SRC_NMI_PIN;
        else if (nmi_req.illegal_op)
            next_source = SRC_ILLEGAL_OP;
        else if (nmi_req.soft_trap)
            next_source = SRC_SOFT_TRAP;
        else if (pending[promoted])
            next_source = index_to_src(promoted);
        else if (any_pending)
            next_source = index_to_src(first_idx);
        else
            next_source = SRC_NONE;
    end

    // Registered every cycle for the core
    always_ff @(posedge clock)
    begin
        if (rst)
            winner <= '0;
        else
        begin
            winner.valid    <= (next_source != SRC_NONE);
            winner.is_reset <= (next_source == SRC_POWER_ON) || (next_source == SRC_CLK_MON)
                               || (next_source == SRC_WATCHDOG);
            winner.source   <= next_source;
            winner.vector   <= {(special_mode_bit ? VEC_HI_SPEC : VEC_HI_NORMAL),
                                vector_low(next_source)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and response, captured in the wait cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            readdata <= 32'h0000_0000;
            response <= RESP_OKAY;
        end
        else if (rd_go)
        begin
            response <= RESP_OKAY;
            unique case (address)
                ADDR_PRIO_MISC: readdata <= {24'h00_0000, boot_rom_read, special_mode_bit,
                                             mode_a_bit, read_visibility_eclk_ctrl, psel};
                ADDR_SYS_CTRL:  readdata <= {24'h00_0000, wd_disabled, nvm_prog, conv_pu,
                                             irq_edge_mode, start_delay, clk_mon_en, wd_rate};
                ADDR_SER_CTRL:  readdata <= {17'h0_0000, ser_bits, baud};
                ADDR_ARB_STAT:  readdata <= {winner.vector, 6'h00, winner.valid,
                                             winner.is_reset, 3'h0, winner.source};
                default:
                begin
                    // Unmapped: zero data and slave error
                    readdata <= 32'h0000_0000;
                    response <= RESP_SLVERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs
    always_comb
    begin
        sys_ctrl.watchdog_run         = ~wd_disabled;
        sys_ctrl.watchdog_rate        = wd_rate;
        sys_ctrl.clock_monitor_enable = clk_mon_en;
        sys_ctrl.startup_delay_enable = start_delay;
        sys_ctrl.converter_power_up   = conv_pu;
        sys_ctrl.nvm_prog_enable      = nvm_prog;
        // Expanded: internal reads shown on the bus
        sys_ctrl.read_visibility      = mode_a_bit & read_visibility_eclk_ctrl;
        // Single-chip and bootstrap: set bit stops the E clock pin
        sys_ctrl.eclk_pin_enable      = mode_a_bit | ~read_visibility_eclk_ctrl;
    end

    always_comb
    begin
        ser_ctrl.baud             = baud;
        ser_ctrl.irq_enables      = ser_bits[0];
        ser_ctrl.tx_enable        = ser_bits[1];
        ser_ctrl.rx_enable        = ser_bits[2];
        ser_ctrl.nine_bit_char    = ser_bits[3];
        ser_ctrl.send_break       = ser_bits[4];
        ser_ctrl.rx_wakeup        = ser_bits[5];
        ser_ctrl.pserial_enable   = ser_bits[6];
        ser_ctrl.tx_empty_flag    = tx_flags;
        ser_ctrl.tx_complete_flag = tx_flags;
        ser_ctrl.rx_flags         = ~tx_flags;
    end

endmodule // rip_ctrl

// [rip_ctrl_bench.sv]
/* Bench for rip_ctrl: mode cases, then arbitration rows and register cases.
   Assumes the bound checker and rip_cpu_model. */
`timescale 1ns/1ps
module rip_ctrl_bench;
    import rip_pkg::*;
    typedef struct packed {
        logic [5:0] nmi; logic irqn; logic [14:0] rq, en; logic im, xm; rip_src_t src; logic [15:0] vec;
    } rip_row_t;
    logic clock = 0, rst = 1, read = 0, write = 0, irq_ack, waitrequest, mode_pin_a = 0, mode_pin_b = 1;
    logic cpu_i_mask = 1, cpu_x_mask = 1, irq_pin_n = 1, watchdog_disable = 0;
    logic [15:0] address = '0;
    logic [31:0] writedata = '0, readdata, q;
    logic [1:0] response;
    logic [14:0] mask_req = '0, mask_en = '0;
    rip_nmi_req_t nmi_req = '0;
    rip_winner_t winner;
    rip_sys_ctrl_t sys_ctrl;
    rip_ser_ctrl_t ser_ctrl;
    int n_errors = 0, total_checks = 0;
    // Straps {b, a} beside the priority register they give
    logic [9:0] modes [4] = '{10'h0c6, 10'h176, 10'h326, 10'h206};
    rip_row_t rows [9] = '{
        '{6'h3f, 1, '1, '1, 0, 0, SRC_POWER_ON, 16'hfffe},
        '{6'h1f, 1, '1, '1, 0, 0, SRC_WATCHDOG, 16'hfffa},
        '{6'h07, 1, '1, '1, 0, 0, SRC_NMI_PIN, 16'hfff4},
        '{6'h07, 1, '1, '1, 0, 1, SRC_ILLEGAL_OP, 16'hfff8},
        '{6'h01, 1, '1, '1, 0, 1, SRC_SOFT_TRAP, 16'hfff6},
        '{6'h00, 0, '1, '1, 0, 1, SRC_IRQ, 16'hfff2},
        '{6'h00, 1, 15'h7ffe, '1, 0, 1, SRC_RTI, 16'hfff0},
        '{6'h00, 1, 15'h7ffc, '1, 0, 1, SRC_CAP1, 16'hffee},
        '{6'h00, 0, '1, '1, 1, 1, SRC_NONE, 16'h0000}};
    rip_ctrl u_dut (.clock, .rst, .address, .read, .write, .writedata, .byteenable(4'hf), .readdata,
        .response, .waitrequest, .mode_pin_a, .mode_pin_b, .watchdog_disable, .cpu_i_mask,
        .cpu_x_mask, .irq_ack, .winner, .nmi_req, .irq_pin_n, .mask_req, .mask_en, .sys_ctrl, .ser_ctrl);
    rip_cpu_model #(.LAT(2)) u_cpu (.clock, .rst, .winner, .irq_ack);
    initial forever #25 clock = ~clock;
    // Hang guard, some 2000 cycles
    initial begin #100_000; n_errors++; test_done; end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) n_errors++;
        if (seen !== exp) $display("mismatch %s expected %h seen %h", name, exp, seen);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
        {read, write, address, writedata} <= {!w, w, a, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        r = readdata;
        {read, write} <= 2'b00;
        @(posedge clock);
    endtask
    // Winner shows one edge after its inputs
    task automatic win(input rip_src_t s, input logic [15:0] v);
        @(posedge clock);
        @(negedge clock);
        chk("source", 32'(winner.source), 32'(s));
        chk("vector", winner.valid ? winner.vector : 16'h0, 32'(v));
        chk("is_reset", 32'(winner.is_reset), 32'(s inside {SRC_POWER_ON, SRC_CLK_MON, SRC_WATCHDOG}));
        @(posedge clock);
    endtask
    initial
    begin
        foreach (modes[i])
        begin
            {rst, mode_pin_b, mode_pin_a, watchdog_disable} <= {1'b1, modes[i][9:8], i == 2};
            repeat (10) @(posedge clock);
            rst <= 0;
            @(posedge clock);
            bus(0, ADDR_PRIO_MISC, '0, q);
            chk("prio_misc", q, 32'(modes[i][7:0]));
            chk("wd_run", 32'(sys_ctrl.watchdog_run), 32'(i != 2));
            // Special modes take the new mode bits, others only the visibility bit
            bus(1, ADDR_PRIO_MISC, 32'h0000_00b6, q);
            bus(0, ADDR_PRIO_MISC, '0, q);
            chk("mode_write", q, modes[i][6] ? 32'h0000_0036 : 32'(modes[i][7:0] | 8'h10));
            chk("vis_eclk", 32'(sys_ctrl[1:0]), (modes[i][6] | modes[i][5]) ? 32'h0000_0003 : 32'h0000_0000);
        end
        foreach (rows[i])
        begin
            {nmi_req, irq_pin_n, mask_req, mask_en, cpu_i_mask, cpu_x_mask} <= rows[i][59:21];
            win(rows[i].src, rows[i].vec);
        end
        cpu_i_mask <= 0;
        bus(1, ADDR_PRIO_MISC, 32'h0000_0080, q);
        bus(0, ADDR_PRIO_MISC, '0, q);
        chk("locked", q, 32'h0000_0006);
        cpu_i_mask <= 1;
        bus(1, ADDR_PRIO_MISC, '0, q);
        bus(0, ADDR_PRIO_MISC, '0, q);
        chk("opened", q, '0);
        {cpu_i_mask, irq_pin_n, mask_req, mask_en} <= {2'b00, 15'h0401, 15'h7fff};
        win(SRC_TIMER_OVF, 16'hffde);
        mask_en <= 15'h03ff;
        win(SRC_IRQ, 16'hfff2);
        {cpu_i_mask, mask_en} <= {1'b1, 15'h7fff};
        bus(1, ADDR_PRIO_MISC, 32'h0000_0005, q);
        cpu_i_mask <= 0;
        win(SRC_IRQ, 16'hfff2);
        // Edge mode: one falling edge pends once, the acknowledge clears it
        {irq_pin_n, mask_req} <= {1'b1, 15'h0000};
        bus(1, ADDR_SYS_CTRL, 32'h0000_0018, q);
        irq_pin_n <= 0;
        @(posedge clock);
        win(SRC_IRQ, 16'hfff2);
        repeat (3) @(posedge clock);
        win(SRC_NONE, 16'h0000);
        bus(0, 16'h1050, '0, q);
        chk("unmapped", {q[29:0], response}, {30'h0, RESP_SLVERR});
        test_done;
    end
endmodule // rip_ctrl_bench

// [rip_ctrl_props.sv]
/* Checker on the rip_ctrl ports.
   Assumes the bind at the foot. */
`timescale 1ns/1ps
module rip_ctrl_props
    import rip_pkg::*;
#(parameter int NUM_SRC = NUM_MASKABLE)
(
    // Clock, reset and bus
    input wire logic clock, rst, read, write, waitrequest,
    input wire logic [15:0] address,
    input wire logic [1:0] response,
    // Masks, requests, results
    input wire logic watchdog_disable, cpu_i_mask,
    input wire rip_nmi_req_t nmi_req,
    input wire rip_winner_t winner,
    input wire rip_sys_ctrl_t sys_ctrl,
    input wire rip_ser_ctrl_t ser_ctrl
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // First cycle of a bus request
    sequence s_req_new;
        (read || write) && waitrequest;
    endsequence
    a_one_wait: assert property (s_req_new |=> !waitrequest)
        else $error("wait too long");
    a_bad_addr: assert property (read && !waitrequest && address == 16'h1050 |-> response == RESP_SLVERR)
        else $error("unmapped read ok");
    a_reset_wins: assert property (nmi_req.power_on |=> winner.source == SRC_POWER_ON)
        else $error("reset lost");
    a_imask_blocks: assert property (nmi_req == '0 && cpu_i_mask |=> !winner.valid)
        else $error("masked winner");
    a_irq_vector: assert property (winner.source == SRC_IRQ |-> winner.vector[7:0] == 8'hf2)
        else $error("irq vector moved");
    a_reset_ctrls: assert property ($fell(rst) |-> sys_ctrl[7:2] == 6'h04)
        else $error("reset controls");
    a_wd_follows: assert property ($fell(rst) |-> sys_ctrl.watchdog_run == !$past(watchdog_disable))
        else $error("watchdog enable");
    a_serial_quiet: assert property ($fell(rst) |-> ser_ctrl == 18'h0_100c)
        else $error("serial reset state");
endmodule // rip_ctrl_props
////////////////////////////////////////////////////////////////
bind rip_ctrl rip_ctrl_props #(.NUM_SRC(NUM_SRC)) u_props (.clock, .rst, .read, .write, .waitrequest,
    .address, .response, .watchdog_disable, .cpu_i_mask, .nmi_req, .winner, .sys_ctrl, .ser_ctrl);

// [rip_pkg.sv]
/*
 * Package for the reset and interrupt priority controller: register byte
 * addresses, field positions, reset values, source identities and carriers.
 * Assumes a 32-bit Avalon-MM register bus with byte addressing.
 */
package rip_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [15:0] ADDR_PRIO_MISC = 16'h103c;  // priority_and_mode_misc
    localparam logic [15:0] ADDR_SYS_CTRL  = 16'h1040;  // System and watchdog controls
    localparam logic [15:0] ADDR_SER_CTRL  = 16'h1044;  // Serial and peripheral-serial controls
    localparam logic [15:0] ADDR_ARB_STAT  = 16'h1048;  // Arbitration status, read only

    // priority_and_mode_misc field positions
    localparam int BIT_BOOT_ROM = 7;
    localparam int BIT_SPECIAL_MODE_BIT     = 6;
    localparam int BIT_MODE_A   = 5;
    localparam int BIT_VIS      = 4;

    // System control field positions
    localparam int BIT_WD_RATE  = 0;  // Two bits
    localparam int BIT_CLK_MON  = 2;
    localparam int BIT_START_DL = 3;
    localparam int BIT_IRQ_EDGE = 4;
    localparam int BIT_CONV_PU  = 5;
    localparam int BIT_NVM_PROG = 6;
    localparam int BIT_WD_DIS   = 7;  // Read only, captured at reset

    // Reset values, reserved selector and vector high bytes
    localparam logic [3:0] PSEL_RESET    = 4'h6;
    localparam logic [3:0] PSEL_RESERVED = 4'h5;
    localparam logic [1:0] WD_RATE_RESET = 2'h0;
    localparam logic [7:0] BAUD_RESET    = 8'h04;
    localparam logic [7:0] VEC_HI_NORMAL = 8'hff;
    localparam logic [7:0] VEC_HI_SPEC   = 8'hbf;

    // Avalon response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Number of maskable sources
    localparam int NUM_MASKABLE = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Every reset and interrupt source, no-winner first
    typedef enum logic [4:0] {
        SRC_NONE, SRC_POWER_ON, SRC_CLK_MON, SRC_WATCHDOG, SRC_NMI_PIN,
        SRC_ILLEGAL_OP, SRC_SOFT_TRAP, SRC_IRQ, SRC_RTI, SRC_CAP1, SRC_CAP2,
        SRC_CAP3, SRC_CMP1, SRC_CMP2, SRC_CMP3, SRC_CMP4, SRC_CAP4_CMP5,
        SRC_TIMER_OVF, SRC_ACC_OVF, SRC_ACC_EDGE, SRC_PSERIAL, SRC_SERIAL
    } rip_src_t;

    // Non-maskable requests, in priority order
    typedef struct packed {
        logic power_on;
        logic clk_mon_fail;
        logic watchdog_timeout;
        logic nmi_pin;
        logic illegal_op;
        logic soft_trap;
    } rip_nmi_req_t;

    // Winner handed to the CPU core
    typedef struct packed {
        logic     valid;
        logic     is_reset;
        rip_src_t source;
        logic [15:0] vector;
    } rip_winner_t;

    // Reset-state controls driven to the peripherals
    typedef struct packed {
        logic       watchdog_run;
        logic [1:0] watchdog_rate;
        logic       clock_monitor_enable;
        logic       startup_delay_enable;
        logic       converter_power_up;
        logic       nvm_prog_enable;
        logic       read_visibility;
        logic       eclk_pin_enable;
    } rip_sys_ctrl_t;

    typedef struct packed {
        logic [7:0] baud;
        logic       irq_enables;   // All serial interrupt enables
        logic       tx_enable;
        logic       rx_enable;
        logic       nine_bit_char;
        logic       send_break;
        logic       rx_wakeup;
        logic       tx_empty_flag;
        logic       tx_complete_flag;
        logic       rx_flags;      // Full, idle, overrun, noise, framing, parity, active
        logic       pserial_enable;
    } rip_ser_ctrl_t;

endpackage
